/* src/pdd_defines.svh */
// Constants for the Device 0 proxy and Multiword DMA strobe decoder
`ifndef PDD_DEFINES_SVH
`define PDD_DEFINES_SVH
// Taskfile addresses on DA2:0
`define PDD_ADDR_DATA 3'h0
`define PDD_ADDR_FEAT 3'h1
`define PDD_ADDR_SCNT 3'h2
`define PDD_ADDR_LBAL 3'h3
`define PDD_ADDR_LBAM 3'h4
`define PDD_ADDR_LBAH 3'h5
`define PDD_ADDR_DEV 3'h6
`define PDD_ADDR_CMD 3'h7
`define PDD_ADDR_CTL 3'h6
// Field positions
`define PDD_DEV_BIT 4
`define PDD_NIEN_BIT 1
`define PDD_SRST_BIT 2
`define PDD_HOB_BIT 7
// Reset values and fixed answers
`define PDD_REG_RST 8'h00
`define PDD_PROXY_READ 8'h00
`define PDD_CMD_DIAG 8'h90
`endif

/* src/pdd_pkg.sv */
// Types shared by the proxy and DMA strobe decoder
package pdd_pkg;
  // Host-side pins after synchronisation
  typedef struct packed {
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic rd_n;
    logic wr_n;
    logic dmack_n;
  } pdd_host_s;
  // Decoder verdict for one strobe
  typedef enum logic [2:0] {
    PDD_IGNORE,
    PDD_DMA_WORD,
    PDD_DMA_LAST,
    PDD_TF_WRITE,
    PDD_TF_READ
  } pdd_kind_e;
  typedef logic [7:0] pdd_byte_t;
endpackage : pdd_pkg

/* src/pdd_proxy_decode.sv */
// Device-side strobe decoder with Device 0 proxy for an absent Device 1
`timescale 1ns/1ps
`default_nettype none
`include "pdd_defines.svh"

// Overview of operation
// [RULE_01] Selected only when stored DEV bit matches own device number.
// [RULE_02] With 48-bit support, HOB picks current or previous taskfile bytes.
// [RULE_03] DMACK, no chip selects, DMARQ and busy or DRQ: one word per strobe.
// [RULE_04] DMACK with DMARQ negated: maybe final burst strobe, else ignored.
// [RULE_05] Strobe with DMACK and any chip select asserted is ignored.
// [RULE_06] Device 0 answers for absent Device 1 while BSY and DRQ clear.
// [RULE_07] Proxy ignores no select, CS1 with DA2 low, or CS1 at 111.
// [RULE_08] Proxy control write loads Device Control; acts on nIEN and SRST.
// [RULE_09] Proxy alternate status read returns zero.
// [RULE_10] Proxy writes Feature at 001; reads there give Error.
// [RULE_11] Proxy writes load Sector Count and LBA Low, Mid, High.
// [RULE_12] Without PACKET, proxy reads of those return own contents.
// [RULE_13] With PACKET, proxy reads of those return zero.
// [RULE_14] Proxy Device write loads Device register and reacts to DEV.
// [RULE_15] Proxy ignores Data port strobes.
// [RULE_16] Proxy Command write stored; only diagnostics is executed.
// [RULE_17] Ignored strobes leave bus undriven and registers unchanged.
module pdd_proxy_decode
  import pdd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic dmack_n,
  input wire logic [15:0] dd_in,
  output logic [15:0] dd_out,
  output logic dd_oe,
  input wire logic dev_num,
  input wire logic dev1_absent,
  input wire logic packet_set,
  input wire logic lba48_set,
  input wire logic bsy,
  input wire logic drq,
  input wire logic dmarq,
  input wire logic [7:0] error_in,
  input wire logic [7:0] status_in,
  input wire logic [15:0] dma_rd_data,
  output logic dma_word_strobe,
  output logic dma_word_write,
  output logic [15:0] dma_wr_data,
  output logic dma_last_strobe,
  output logic cmd_strobe,
  output logic diag_strobe,
  output logic [7:0] cmd_out,
  output logic selected,
  output logic nien,
  output logic srst,
  output logic [7:0] feature_out,
  output logic [7:0] sec_cnt_out,
  output logic [7:0] lba_low_out,
  output logic [7:0] lba_mid_out,
  output logic [7:0] lba_high_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Two flops on every host pin; the first stage feeds only the second
  pdd_host_s meta_reg;
  pdd_host_s host_reg;
  pdd_host_s host_prev_reg;
  pdd_host_s pin_now;
  logic [15:0] dd_meta_reg;
  logic [15:0] dd_sync_reg;
  assign pin_now = '{cs0_n, cs1_n, da, dior_n, diow_n, dmack_n};
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_reg <= '1;
      host_reg <= '1;
      host_prev_reg <= '1;
      dd_meta_reg <= 16'h0000;
      dd_sync_reg <= 16'h0000;
    end else begin
      meta_reg <= pin_now;
      host_reg <= meta_reg;
      host_prev_reg <= host_reg;
      dd_meta_reg <= dd_in;
      dd_sync_reg <= dd_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Strobe edges
  // ---------------------------------------------------------------
  // Act on the falling edge; address and data are stable by then
  // after two flops of settling, a limit on very short strobe timing
  wire rd_fall = host_prev_reg.rd_n && !host_reg.rd_n;
  wire wr_fall = host_prev_reg.wr_n && !host_reg.wr_n;
  wire any_fall = rd_fall || wr_fall;
  wire rd_active = !host_reg.rd_n;

  // ---------------------------------------------------------------
  // Taskfile storage
  // ---------------------------------------------------------------
  pdd_byte_t feat_reg, scnt_reg, lbal_reg, lbam_reg, lbah_reg;
  pdd_byte_t scnt_old_reg, lbal_old_reg, lbam_old_reg, lbah_old_reg;
  pdd_byte_t dev_reg, ctl_reg, cmd_reg;

  // Selection from the stored DEV bit
  wire dev_bit = dev_reg[`PDD_DEV_BIT];
  wire is_sel = (dev_bit == dev_num); // [RULE_01]
  wire dev1_sel = dev_bit;
  wire proxy = (dev_num == 1'b0) && dev1_sel && dev1_absent
    && !bsy && !drq; // [RULE_06]

  // DMA decode
  wire dmack = !host_reg.dmack_n;
  wire cs0 = !host_reg.cs0_n;
  wire cs1 = !host_reg.cs1_n;
  wire dma_path = is_sel && dmack && !cs0 && !cs1;
  wire dma_word = dma_path && dmarq && (bsy || drq); // [RULE_03]
  wire dma_last = dma_path && !dmarq; // [RULE_04]
  // Chip select during DMACK leaves dma_path low, so the strobe drops
  // into neither DMA nor taskfile decode [RULE_05]
  wire tf_ok = !dmack && (is_sel || proxy);

  // Taskfile address decode
  wire [2:0] a = host_reg.da;
  wire cmd_blk = cs0 && !cs1;
  wire ctl_blk = cs1 && !cs0;
  wire ctl_hit = ctl_blk && (a == `PDD_ADDR_CTL); // [RULE_07]
  wire cmd_hit = cmd_blk && (a != `PDD_ADDR_DATA); // [RULE_15]
  wire tf_hit = tf_ok && (ctl_hit || cmd_hit);
  wire tf_wr = tf_hit && wr_fall;
  wire wr_feat = tf_wr && cmd_blk && (a == `PDD_ADDR_FEAT); // [RULE_10]
  wire wr_scnt = tf_wr && cmd_blk && (a == `PDD_ADDR_SCNT); // [RULE_11]
  wire wr_lbal = tf_wr && cmd_blk && (a == `PDD_ADDR_LBAL);
  wire wr_lbam = tf_wr && cmd_blk && (a == `PDD_ADDR_LBAM);
  wire wr_lbah = tf_wr && cmd_blk && (a == `PDD_ADDR_LBAH);
  wire wr_dev = tf_wr && cmd_blk && (a == `PDD_ADDR_DEV); // [RULE_14]
  wire wr_cmd = tf_wr && cmd_blk && (a == `PDD_ADDR_CMD); // [RULE_16]
  wire wr_ctl = tf_wr && ctl_hit; // [RULE_08]
  wire [7:0] wbyte = dd_sync_reg[7:0];

  // Register stores; an ignored strobe leaves all of them as they were
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      feat_reg <= `PDD_REG_RST;
      scnt_reg <= `PDD_REG_RST;
      lbal_reg <= `PDD_REG_RST;
      lbam_reg <= `PDD_REG_RST;
      lbah_reg <= `PDD_REG_RST;
      scnt_old_reg <= `PDD_REG_RST;
      lbal_old_reg <= `PDD_REG_RST;
      lbam_old_reg <= `PDD_REG_RST;
      lbah_old_reg <= `PDD_REG_RST;
      dev_reg <= `PDD_REG_RST;
      ctl_reg <= `PDD_REG_RST;
      cmd_reg <= `PDD_REG_RST;
    end else begin
      if (wr_feat) feat_reg <= wbyte; // [RULE_17]
      // Old byte kept for the HOB read-back
      if (wr_scnt) begin
        scnt_old_reg <= scnt_reg;
        scnt_reg <= wbyte; // [RULE_11]
      end
      if (wr_lbal) begin
        lbal_old_reg <= lbal_reg;
        lbal_reg <= wbyte;
      end
      if (wr_lbam) begin
        lbam_old_reg <= lbam_reg;
        lbam_reg <= wbyte;
      end
      if (wr_lbah) begin
        lbah_old_reg <= lbah_reg;
        lbah_reg <= wbyte;
      end
      if (wr_dev) dev_reg <= wbyte; // [RULE_14]
      if (wr_ctl) ctl_reg <= wbyte; // [RULE_08]
      if (wr_cmd) cmd_reg <= wbyte; // [RULE_16]
    end
  end

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  // HOB only counts when 48-bit addressing is offered
  wire hob = lba48_set && ctl_reg[`PDD_HOB_BIT]; // [RULE_02]
  wire [7:0] scnt_rd = hob ? scnt_old_reg : scnt_reg;
  wire [7:0] lbal_rd = hob ? lbal_old_reg : lbal_reg;
  wire [7:0] lbam_rd = hob ? lbam_old_reg : lbam_reg;
  wire [7:0] lbah_rd = hob ? lbah_old_reg : lbah_reg;
  // Proxy with PACKET hides the signature bytes [RULE_13]
  wire zero_lba = proxy && packet_set;
  logic [7:0] tf_byte;
  always_comb begin
    tf_byte = 8'h00;
    if (ctl_blk) begin
      tf_byte = proxy ? `PDD_PROXY_READ : status_in; // [RULE_09]
    end else begin
      case (a)
        `PDD_ADDR_FEAT: tf_byte = error_in; // [RULE_10]
        `PDD_ADDR_SCNT: tf_byte = zero_lba ? 8'h00 : scnt_rd; // [RULE_12]
        `PDD_ADDR_LBAL: tf_byte = zero_lba ? 8'h00 : lbal_rd;
        `PDD_ADDR_LBAM: tf_byte = zero_lba ? 8'h00 : lbam_rd;
        `PDD_ADDR_LBAH: tf_byte = zero_lba ? 8'h00 : lbah_rd;
        `PDD_ADDR_DEV: tf_byte = dev_reg;
        `PDD_ADDR_CMD: tf_byte = proxy ? `PDD_PROXY_READ : status_in;
        default: tf_byte = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bus drive and event pulses
  // ---------------------------------------------------------------
  // The driven word is captured at the strobe edge and held while
  // the read strobe stays low; ignored strobes never enable the bus
  logic drive_reg;
  logic [15:0] dout_reg;
  logic dma_word_reg, dma_wr_reg, dma_last_reg, cmd_reg_p, diag_reg;
  logic [15:0] dma_wd_reg;
  wire rd_tf = rd_fall && tf_hit;
  wire rd_dma = rd_fall && dma_word;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      drive_reg <= 1'b0;
      dout_reg <= 16'h0000;
      dma_word_reg <= 1'b0;
      dma_wr_reg <= 1'b0;
      dma_wd_reg <= 16'h0000;
      dma_last_reg <= 1'b0;
      cmd_reg_p <= 1'b0;
      diag_reg <= 1'b0;
    end else begin
      if (rd_tf || rd_dma) drive_reg <= 1'b1;
      else if (!rd_active) drive_reg <= 1'b0; // [RULE_17]
      if (rd_tf) dout_reg <= {8'h00, tf_byte};
      else if (rd_dma) dout_reg <= dma_rd_data; // [RULE_03]
      dma_word_reg <= any_fall && dma_word;
      dma_wr_reg <= wr_fall && dma_word;
      if (wr_fall && dma_word) dma_wd_reg <= dd_sync_reg;
      dma_last_reg <= any_fall && dma_last; // [RULE_04]
      cmd_reg_p <= wr_cmd && !proxy;
      diag_reg <= wr_cmd && (wbyte == `PDD_CMD_DIAG); // [RULE_16]
    end
  end

  assign dd_out = dout_reg;
  assign dd_oe = drive_reg;
  assign dma_word_strobe = dma_word_reg;
  assign dma_word_write = dma_wr_reg;
  assign dma_wr_data = dma_wd_reg;
  assign dma_last_strobe = dma_last_reg;
  assign cmd_strobe = cmd_reg_p;
  assign diag_strobe = diag_reg;
  assign cmd_out = cmd_reg;
  assign selected = is_sel;
  assign nien = ctl_reg[`PDD_NIEN_BIT]; // [RULE_08]
  assign srst = ctl_reg[`PDD_SRST_BIT];
  assign feature_out = feat_reg;
  assign sec_cnt_out = scnt_reg;
  assign lba_low_out = lbal_reg;
  assign lba_mid_out = lbam_reg;
  assign lba_high_out = lbah_reg;

endmodule : pdd_proxy_decode
`default_nettype wire

/* tb/pdd_host_model.sv */
// Host adapter model driving chip selects, address, strobes and data
`timescale 1ns/1ps
`default_nettype none
module pdd_host_model (
  input wire logic core_clk,
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] da,
  output logic dior_n,
  output logic diow_n,
  output logic dmack_n,
  output logic [15:0] dd_in,
  input wire logic [15:0] dd_out,
  input wire logic dd_oe
);
  // ----------------------------------------
  // Pin sequencing
  // ----------------------------------------
  // Idle selects, strobes and DMACK high; address and data low
  initial begin
    {cs0_n, cs1_n, dior_n, diow_n, dmack_n} = 5'h1f;
    da = 3'h0;
    dd_in = 16'h0000;
  end
  // One strobe; cs is {cs0, cs1} active high, long holds suit the syncs
  task automatic xfer(input logic [1:0] cs, input logic [2:0] a,
      input logic wr, input logic dma, input logic [15:0] d,
      output logic [15:0] q, output logic oe);
    @(posedge core_clk);
    cs0_n <= ~cs[1];
    cs1_n <= ~cs[0];
    da <= a;
    dmack_n <= ~dma;
    dd_in <= d;
    repeat (4) @(posedge core_clk);
    dior_n <= wr;
    diow_n <= ~wr;
    repeat (8) @(posedge core_clk);
    q = dd_out;
    oe = dd_oe;
    dior_n <= 1'b1;
    diow_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    {cs0_n, cs1_n, dmack_n} <= 3'h7;
    dd_in <= ~d;  // Released bus must not echo the last word
    repeat (4) @(posedge core_clk);
  endtask : xfer
endmodule : pdd_host_model
`default_nettype wire

/* tb/pdd_proxy_decode_properties.sv */
// Port-level checks for the proxy and DMA strobe decoder
`timescale 1ns/1ps
`default_nettype none
module pdd_proxy_decode_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic dior_n,
  input wire logic dmack_n,
  input wire logic [15:0] dd_out,
  input wire logic dd_oe,
  input wire logic bsy,
  input wire logic drq,
  input wire logic dmarq,
  input wire logic dma_word_strobe,
  input wire logic dma_word_write,
  input wire logic dma_last_strobe,
  input wire logic cmd_strobe,
  input wire logic diag_strobe,
  input wire logic [7:0] cmd_out,
  input wire logic selected
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_cmd_needs_sel: assert property (cmd_strobe |-> selected)
    else $error("command run while not selected");
  a_diag_code: assert property (diag_strobe |-> cmd_out == 8'h90)
    else $error("diagnostic pulse with other code");
  a_word_cause: assert property (dma_word_strobe |->
    $past(dmarq) && ($past(bsy) || $past(drq)))
    else $error("dma word without request");
  a_last_cause: assert property (dma_last_strobe |-> !$past(dmarq))
    else $error("last strobe with request active");
  a_word_once: assert property (dma_word_strobe |=> !dma_word_strobe[*3])
    else $error("dma word pulse repeated");
  a_dma_no_cs: assert property (dma_word_strobe |->
    $past(cs0_n, 3) && $past(cs1_n, 3))
    else $error("dma word taken with chip select");
  a_oe_release: assert property ($rose(dior_n) |-> ##[1:6] !dd_oe)
    else $error("bus still driven after read");
  a_oe_cause: assert property ($rose(dd_oe) |-> !$past(dior_n, 2))
    else $error("bus driven without read strobe");
  a_dma_wr_quiet: assert property (dma_word_write |-> !dd_oe)
    else $error("bus driven on dma write");
  a_byte_high: assert property (dd_oe && dmack_n && $past(dmack_n, 8)
    |-> dd_out[15:8] == 8'h00)
    else $error("taskfile read upper byte set");
  // Main scenarios reached
  c_last: cover property (dma_last_strobe);
  c_diag: cover property (diag_strobe && !cmd_strobe);
  c_dma_rd: cover property (dma_word_strobe && !dma_word_write);
endmodule : pdd_proxy_decode_properties
bind pdd_proxy_decode pdd_proxy_decode_properties i_props (.core_clk,
  .reset_n, .cs0_n, .cs1_n, .dior_n, .dmack_n, .dd_out, .dd_oe, .bsy,
  .drq, .dmarq, .dma_word_strobe, .dma_word_write, .dma_last_strobe,
  .cmd_strobe, .diag_strobe, .cmd_out, .selected);
`default_nettype wire

/* tb/pdd_proxy_decode_tb.sv */
// Self-checking bench for the proxy and DMA strobe decoder
`timescale 1ns/1ps
`default_nettype none
module pdd_proxy_decode_tb;
  logic core_clk = 1'b0;
  logic reset_n, dev_num, dev1_absent, packet_set, lba48_set;
  logic bsy, drq, dmarq, oe, dd_oe, selected, nien, srst;
  logic [7:0] error_in, status_in, cmd_out;
  logic [15:0] dma_rd_data, q, dd_out, dma_wr_data;
  logic dma_word_strobe, dma_word_write, dma_last_strobe;
  logic cmd_strobe, diag_strobe;
  int n_word = 0;
  int n_wrw = 0;
  int n_last = 0;
  int n_cmd = 0;
  int n_diag = 0;
  wire logic cs0_n, cs1_n, dior_n, diow_n, dmack_n;
  wire logic [2:0] da;
  wire logic [15:0] dd_in;
  wire logic [7:0] tf [1:5];
  int n_errors = 0;
  int compares = 0;
  always #5 core_clk = ~core_clk;
  // Pulse counters; each pulse stands one cycle, so count every edge
  always @(posedge core_clk) begin
    if (dma_word_strobe) n_word++;
    if (dma_word_write) n_wrw++;
    if (dma_last_strobe) n_last++;
    if (cmd_strobe) n_cmd++;
    if (diag_strobe) n_diag++;
  end
  pdd_host_model i_pdd_host_model (.core_clk, .cs0_n, .cs1_n, .da,
    .dior_n, .diow_n, .dmack_n, .dd_in, .dd_out, .dd_oe);
  pdd_proxy_decode i_pdd_proxy_decode (.core_clk, .reset_n, .cs0_n,
    .cs1_n, .da, .dior_n, .diow_n, .dmack_n, .dd_in, .dd_out, .dd_oe,
    .dev_num, .dev1_absent, .packet_set, .lba48_set, .bsy, .drq, .dmarq,
    .error_in, .status_in, .dma_rd_data, .dma_word_strobe,
    .dma_word_write, .dma_wr_data, .dma_last_strobe, .cmd_strobe,
    .diag_strobe, .cmd_out, .selected, .nien, .srst,
    .feature_out(tf[1]), .sec_cnt_out(tf[2]), .lba_low_out(tf[3]),
    .lba_mid_out(tf[4]), .lba_high_out(tf[5]));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [1:0] cs, input logic [2:0] a,
      input logic [7:0] d);
    i_pdd_host_model.xfer(cs, a, 1'b1, 1'b0, {8'h00, d}, q, oe);
  endtask : wr
  // Read; a refused read must leave the bus undriven
  task automatic rd(input logic [1:0] cs, input logic [2:0] a,
      input logic [15:0] e, input logic eoe);
    i_pdd_host_model.xfer(cs, a, 1'b0, 1'b0, 16'h0000, q, oe);
    chk("drive", {15'h0, eoe}, {15'h0, oe});
    if (eoe)
      chk("read", e, q);
  endtask : rd
  task automatic give_verdict;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end
  // Main sequence; proxy needs device 0 with device 1 absent
  initial begin
    {reset_n, dev_num, packet_set, lba48_set, bsy, drq, dmarq} = 7'h00;
    dev1_absent = 1'b1;
    error_in = 8'h5c;
    status_in = 8'h50;
    dma_rd_data = 16'h1234;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("reset", 16'h1, {12'h0, dd_oe, nien, srst, selected});
    wr(2'b10, 3'h6, 8'h10);
    chk("selected", 16'h0, {15'h0, selected});
    for (int a = 1; a < 6; a++) begin
      wr(2'b10, a[2:0], {a[3:0], a[3:0]});
      chk("taskfile", {8'h00, a[3:0], a[3:0]}, {8'h00, tf[a]});
    end
    rd(2'b10, 3'h1, {8'h00, error_in}, 1'b1);
    for (int a = 2; a < 6; a++)
      rd(2'b10, a[2:0], {8'h00, a[3:0], a[3:0]}, 1'b1);
    wr(2'b11, 3'h2, 8'hee);
    chk("ignored", 16'h0022, {8'h00, tf[2]});
    packet_set <= 1'b1;
    for (int a = 2; a < 6; a++)
      rd(2'b10, a[2:0], 16'h0000, 1'b1);
    rd(2'b01, 3'h6, 16'h0000, 1'b1);
    rd(2'b10, 3'h0, 16'h0000, 1'b0);
    rd(2'b00, 3'h6, 16'h0000, 1'b0);
    rd(2'b01, 3'h3, 16'h0000, 1'b0);
    rd(2'b01, 3'h7, 16'h0000, 1'b0);
    wr(2'b01, 3'h6, 8'h06);
    chk("control", 16'h3, {14'h0, srst, nien});
    wr(2'b01, 3'h6, 8'h00);
    wr(2'b10, 3'h7, 8'h90);
    chk("command", 16'h0090, {8'h00, cmd_out});
    wr(2'b10, 3'h6, 8'h00);
    chk("selected", 16'h1, {15'h0, selected});
    wr(2'b10, 3'h7, 8'h20);
    chk("command", 16'h0020, {8'h00, cmd_out});
    chk("cmd pulses", 16'h1, n_cmd[15:0]);
    chk("diag pulses", 16'h1, n_diag[15:0]);
    // Previous byte comes back when HOB is set
    lba48_set <= 1'b1;
    wr(2'b10, 3'h2, 8'h01);
    wr(2'b10, 3'h2, 8'h02);
    wr(2'b01, 3'h6, 8'h80);
    rd(2'b10, 3'h2, 16'h0001, 1'b1);
    dmarq <= 1'b1;
    bsy <= 1'b1;
    i_pdd_host_model.xfer(2'b00, 3'h0, 1'b1, 1'b1, 16'ha55a, q, oe);
    chk("dma write", 16'ha55a, dma_wr_data);
    i_pdd_host_model.xfer(2'b00, 3'h0, 1'b0, 1'b1, 16'h0000, q, oe);
    chk("dma read", 16'h1234, q);
    i_pdd_host_model.xfer(2'b10, 3'h0, 1'b1, 1'b1, 16'h5aa5, q, oe);
    chk("dma write", 16'ha55a, dma_wr_data);
    dmarq <= 1'b0;
    i_pdd_host_model.xfer(2'b00, 3'h0, 1'b1, 1'b1, 16'h0f0f, q, oe);
    chk("last pulses", 16'h1, n_last[15:0]);
    chk("word pulses", 16'h2, n_word[15:0]);
    chk("write pulses", 16'h1, n_wrw[15:0]);
    chk("dma write", 16'ha55a, dma_wr_data);
    give_verdict();
  end
endmodule : pdd_proxy_decode_tb
`default_nettype wire
